// *** src/soft_reset_ctl.sv ***
// Soft reset control and clock output pad configuration registers.
// Assumes the slave control port front end stays clocked and hands
// over decoded accesses; other control logic obeys o_soft_rst_b.
//
// What this block does
// [RULE1] Reinit bit 0 is active low: 0 holds soft reset, 1 runs (reset 1).
// [RULE2] Soft reset restores the pad default but spares the synth registers.
// [RULE3] Host register access keeps working while soft reset is held.
// [RULE4] Host writes to the synth registers are taken during soft reset.
// [RULE5] SPI port mode stays set during and after a soft reset.
// [RULE6] Only the hardware reset pin returns the port to I2C mode.
// [RULE7] Pad register: pull-down enable bit 4, slew 3:2, drive 1:0.
// [RULE8] Pad resets to 0x0008: fast slew, lowest drive, pull-down off.
// [RULE9] Reserved upper bits read as zero and should be written as zero.
`timescale 1ns/1ps
module soft_reset_ctl
  import soft_reset_pkg::*;
(
  // Clock and hardware reset pin
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Decoded host access from the slave control port
  input wire reg_req_t i_req,
  input wire logic i_spi_select,
  // Read answer
  output logic [15:0] o_rdata,
  output logic o_rd_valid,
  // Controls to the rest of the device
  output logic o_soft_rst_b,
  output logic o_spi_mode,
  output pad_cfg_t o_pad,
  output synth_regs_t o_synth_regs
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ctl_state_t st;
  ctl_state_t next_st;
  logic synth_hit;
  logic [15:0] synth_rdata;
  logic hit_pad;
  logic hit_reinit;
  localparam ctl_state_t ST_RESET = '{
    reinit_n: REINIT_RESET[REINIT_BIT],
    pad: pad_cfg_t'(PAD_RESET[PAD_FIELD_W-1:0]),
    mode: PORT_I2C,
    rdata: 16'h0000,
    rd_valid: 1'b0
  };

  assign hit_pad = i_req.addr == PAD_CFG_ADDR;
  assign hit_reinit = i_req.addr == REINIT_ADDR;

  // ****************************************************************
  // Clock synthesis group
  // ****************************************************************
  // Sees every write, soft reset or not [RULE4]
  synth_reg_bank u_synth (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_wr(i_req.wr),
    .i_addr(i_req.addr),
    .i_wdata(i_req.wdata),
    .o_hit(synth_hit),
    .o_rdata(synth_rdata),
    .o_regs(o_synth_regs)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    // Active-low soft reset bit, always writable so software can exit
    if (i_req.wr && hit_reinit) begin
      next_st.reinit_n = i_req.wdata[REINIT_BIT]; // [RULE1]
    end
    // Pad fields; writes during soft reset are dropped [RULE7]
    if (i_req.wr && hit_pad) begin
      next_st.pad.pulldown_en = i_req.wdata[PAD_PULL_BIT];
      next_st.pad.slew_sel = i_req.wdata[PAD_SLEW_HI:PAD_SLEW_LO];
      next_st.pad.drive_sel = i_req.wdata[PAD_DRIVE_HI:PAD_DRIVE_LO];
    end
    // Held at default while soft reset is in force [RULE2] [RULE8]
    if (!st.reinit_n) begin
      next_st.pad = ST_RESET.pad;
    end
    // Sticky mode; soft reset does not touch it [RULE5] [RULE6]
    if (i_spi_select) begin
      next_st.mode = PORT_SPI;
    end
    // Reads answered in soft reset too [RULE3]
    if (i_req.rd) begin
      next_st.rd_valid = 1'b1;
      // Upper bits zero-filled, reserved reads as zero [RULE9]
      if (hit_pad) begin
        next_st.rdata = {{(DATA_W-PAD_FIELD_W){1'b0}}, st.pad};
      end else if (hit_reinit) begin
        next_st.rdata = {{(DATA_W-1){1'b0}}, st.reinit_n};
      end else if (synth_hit) begin
        next_st.rdata = synth_rdata;
      end else begin
        next_st.rdata = 16'h0000; // Unmapped reads as zero
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Only the pin reset reaches here; mode reverts to I2C [RULE6]
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign o_rdata = st.rdata;
  assign o_rd_valid = st.rd_valid;
  assign o_soft_rst_b = st.reinit_n;
  assign o_spi_mode = st.mode == PORT_SPI;
  assign o_pad = st.pad;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_enter_soft;
    i_req.wr && hit_reinit && !i_req.wdata[REINIT_BIT];
  endsequence

  sequence s_pad_write_run;
    i_req.wr && hit_pad && st.reinit_n && !(i_req.wr && hit_reinit);
  endsequence

  // Exit path; a lost exit would lock software out for good
  sequence s_leave_soft;
    i_req.wr && hit_reinit && i_req.wdata[REINIT_BIT];
  endsequence

  a_soft_bit_low: assert property ( // [RULE1]
    @(posedge i_mclk) disable iff (!i_rst_b)
    s_enter_soft |=> !o_soft_rst_b)
    else $error("soft reset bit did not take zero");

  a_pad_default_soft: assert property ( // [RULE8]
    @(posedge i_mclk) disable iff (!i_rst_b)
    s_enter_soft ##1 1'b1 |=> (o_pad == ST_RESET.pad))
    else $error("pad register not at default in soft reset");

  a_pad_held_soft: assert property ( // [RULE2]
    @(posedge i_mclk) disable iff (!i_rst_b)
    !o_soft_rst_b |=> (o_pad == ST_RESET.pad))
    else $error("pad register moved during soft reset");

  a_pad_fields: assert property ( // [RULE7]
    @(posedge i_mclk) disable iff (!i_rst_b)
    s_pad_write_run |=>
      (o_pad.pulldown_en == $past(i_req.wdata[PAD_PULL_BIT]))
      && (o_pad.slew_sel == $past(i_req.wdata[PAD_SLEW_HI:PAD_SLEW_LO]))
      && (o_pad.drive_sel == $past(i_req.wdata[PAD_DRIVE_HI:PAD_DRIVE_LO])))
    else $error("pad field placement wrong");

  a_port_live: assert property ( // [RULE3]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_req.rd && !o_soft_rst_b) |=> o_rd_valid)
    else $error("read not answered during soft reset");

  a_spi_sticky: assert property ( // [RULE5]
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_spi_mode |=> o_spi_mode)
    else $error("port left SPI mode without pin reset");

  a_spi_entry: assert property ( // [RULE6]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!o_spi_mode && !i_spi_select) |=> !o_spi_mode)
    else $error("port entered SPI mode unprompted");

  a_reserved_zero: assert property ( // [RULE9]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_req.rd && (hit_pad || hit_reinit))
      |=> (o_rdata[DATA_W-1:PAD_FIELD_W] == '0))
    else $error("reserved bits read nonzero");

  // Software must always be able to leave soft reset again
  a_soft_bit_high: assert property ( // [RULE1]
    @(posedge i_mclk) disable iff (!i_rst_b)
    s_leave_soft |=> o_soft_rst_b)
    else $error("soft reset bit did not take one");

  // Only a reinit write moves the level; soft reset must not self-release
  a_reinit_kept: assert property ( // [RULE1]
    @(posedge i_mclk) disable iff (!i_rst_b)
    !(i_req.wr && hit_reinit) |=> $stable(o_soft_rst_b))
    else $error("soft reset level moved without write");

  a_reinit_read: assert property ( // [RULE1]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_req.rd && hit_reinit)
      |=> (o_rdata[REINIT_BIT] == $past(o_soft_rst_b)))
    else $error("reinit bit read back wrong");

  // Read answer is a one-cycle pulse
  a_rd_one_cycle: assert property ( // [RULE3]
    @(posedge i_mclk) disable iff (!i_rst_b)
    !i_req.rd |=> !o_rd_valid)
    else $error("read valid without read");

  // Read data holds until the next read, so a slow host still sees it
  a_rdata_held: assert property ( // [RULE3]
    @(posedge i_mclk) disable iff (!i_rst_b)
    !i_req.rd |=> $stable(o_rdata))
    else $error("read data changed without read");

  a_synth_read: assert property ( // [RULE3]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_req.rd && synth_hit) |=> (o_rdata == $past(synth_rdata)))
    else $error("synth register read back wrong");

  // Soft reset leaves the synth group alone; only writes change it
  a_synth_spared: assert property ( // [RULE2]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!o_soft_rst_b && !(i_req.wr && synth_hit)) |=> $stable(o_synth_regs))
    else $error("synth group touched by soft reset");

  // While running, pad settings move only on a pad write
  a_pad_idle: assert property ( // [RULE7]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (o_soft_rst_b && !(i_req.wr && hit_pad)) |=> $stable(o_pad))
    else $error("pad register changed without write");

  a_spi_taken: assert property ( // [RULE5]
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_spi_select |=> o_spi_mode)
    else $error("port did not enter SPI mode");

endmodule

// *** shared/soft_reset_pkg.sv ***
// Constants and types for the soft reset and clock pad control block.
// Assumes a slave control port front end that hands over decoded
// 16-bit register accesses.
package soft_reset_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] PAD_CFG_ADDR = 16'hf7a3;
  localparam logic [15:0] REINIT_ADDR = 16'hf890;
  localparam logic [15:0] SYNTH_BASE = 16'hf000;
  localparam logic [15:0] SYNTH_LAST = 16'hf006;
  localparam int SYNTH_COUNT = 7;
  localparam int SYNTH_IDX_W = 3;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [15:0] PAD_RESET = 16'h0008;
  localparam logic [15:0] REINIT_RESET = 16'h0001;
  localparam logic [15:0] SYNTH_RESET = 16'h0000;
  localparam int PAD_PULL_BIT = 4;
  localparam int PAD_SLEW_HI = 3;
  localparam int PAD_SLEW_LO = 2;
  localparam int PAD_DRIVE_HI = 1;
  localparam int PAD_DRIVE_LO = 0;
  localparam int PAD_FIELD_W = 5;
  localparam int REINIT_BIT = 0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {PORT_I2C, PORT_SPI} port_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic pulldown_en;
    logic [1:0] slew_sel;
    logic [1:0] drive_sel;
  } pad_cfg_t;

  typedef logic [SYNTH_COUNT-1:0][15:0] synth_regs_t;

  typedef struct packed {
    logic reinit_n;
    pad_cfg_t pad;
    port_mode_t mode;
    logic [15:0] rdata;
    logic rd_valid;
  } ctl_state_t;

  typedef struct packed {
    synth_regs_t regs;
  } synth_state_t;

endpackage

// *** src/synth_reg_bank.sv ***
// Clock synthesis register group, cleared only by the hardware reset.
// Assumes the caller forwards every host write; soft reset never
// reaches this bank.
`timescale 1ns/1ps
module synth_reg_bank
  import soft_reset_pkg::*;
(
  // Clock and hardware reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Decoded access
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  // Read side and contents
  output logic o_hit,
  output logic [15:0] o_rdata,
  output synth_regs_t o_regs
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  synth_state_t st;
  synth_state_t next_st;
  logic [SYNTH_IDX_W-1:0] idx;
  logic [SYNTH_COUNT-1:0] wr_hit;

  // Offset into the group, cut to index width
  assign o_hit = (i_addr >= SYNTH_BASE) && (i_addr <= SYNTH_LAST);
  assign idx = SYNTH_IDX_W'(i_addr - SYNTH_BASE);
  assign o_rdata = o_hit ? st.regs[idx] : 16'h0000;
  assign o_regs = st.regs;

  // Per-entry write strobes
  genvar g;
  generate
    for (g = 0; g < SYNTH_COUNT; g++) begin : g_entry
      assign wr_hit[g] = i_wr && o_hit && (idx == SYNTH_IDX_W'(g));
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************
  // Writes land regardless of soft reset state [RULE4]
  always_comb begin
    next_st = st;
    for (int k = 0; k < SYNTH_COUNT; k++) begin
      if (wr_hit[k]) begin
        next_st.regs[k] = i_wdata;
      end
    end
  end

  // Only the hardware reset clears the group [RULE2]
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '{regs: {SYNTH_COUNT{SYNTH_RESET}}};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_synth_write_lands: assert property ( // [RULE4]
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_wr && o_hit) |=> (st.regs[$past(idx)] == $past(i_wdata)))
    else $error("synth register write lost");

  a_synth_kept_idle: assert property ( // [RULE2]
    @(posedge i_mclk) disable iff (!i_rst_b)
    !(i_wr && o_hit) |=> $stable(st.regs))
    else $error("synth register changed without write");

endmodule

// *** tb/host_model.sv ***
// Host model: issues decoded register accesses and the SPI switch.
// Assumes the device answers a read on the taking edge, visible just after it.
`timescale 1ns/1ps
module host_model
  import soft_reset_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Read answer
  input wire logic [15:0] i_rdata,
  input wire logic i_rd_valid,
  // Requests to the device
  output reg_req_t o_req,
  output logic o_spi_select
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle bus from time zero, so no access leaks out of reset
  initial begin
    o_req = '0;
    o_spi_select = 1'b0;
  end

  // Request held for one taking edge, answer taken just after it
  task automatic access(input logic wr, input logic rd,
      input logic [15:0] addr, input logic [15:0] wdata,
      output logic [15:0] rdata, output logic vld);
    @(posedge i_mclk);
    o_req <= '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    @(posedge i_mclk);
    o_req <= '0;
    #1;
    rdata = i_rdata;
    vld = i_rd_valid;
  endtask

  // Front end reports the port switched to SPI
  task automatic spi_pulse();
    @(posedge i_mclk);
    o_spi_select <= 1'b1;
    @(posedge i_mclk);
    o_spi_select <= 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the soft reset and clock pad block.
// Assumes the host model is the only source of register accesses.
`timescale 1ns/1ps
module tb_top
  import soft_reset_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  reg_req_t req;
  logic spi_sel, rd_valid, soft_rst_b, spi_mode, vld;
  logic [15:0] rdata, rd_v, d;
  pad_cfg_t pad;
  synth_regs_t synth, synth_exp;
  int n_errors = 0;
  int num_checks = 0;

  // 20 MHz clock
  always #25 i_mclk = ~i_mclk;

  soft_reset_ctl i_dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req),
    .i_spi_select(spi_sel), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_soft_rst_b(soft_rst_b), .o_spi_mode(spi_mode), .o_pad(pad),
    .o_synth_regs(synth));

  host_model i_host (
    .i_mclk(i_mclk), .i_rdata(rdata), .i_rd_valid(rd_valid),
    .o_req(req), .o_spi_select(spi_sel));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] pad_exp(input logic [15:0] v);
    return {11'h000, v[4:0]};
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] exp,
      input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    i_host.access(1'b1, 1'b0, a, v, rd_v, vld);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    i_host.access(1'b0, 1'b1, a, 16'h0000, rd_v, vld);
    check(vld, 1'b1, "read valid");
    check(rd_v, e, "read data");
    @(posedge i_mclk);
    #1;
    check(rd_valid, 1'b0, "read valid one cycle");
  endtask

  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard; a run that exceeds it fails
  initial begin
    repeat (5000) @(posedge i_mclk);
    n_errors++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(51075));
    synth_exp = '0;
    repeat (8) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    #1;
    check(soft_rst_b, 1'b1, "run after reset");
    check(pad, 5'h08, "pad default");
    check(spi_mode, 1'b0, "mode default");
    rd_chk(PAD_CFG_ADDR, PAD_RESET);
    rd_chk(REINIT_ADDR, REINIT_RESET);
    rd_chk(16'hf891, 16'h0000);
    // Pad fields; reserved bits set on purpose to see them read zero
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom());
      wr(PAD_CFG_ADDR, d);
      check(pad, d[4:0], "pad fields");
      rd_chk(PAD_CFG_ADDR, pad_exp(d));
    end
    // Whole synth group with random contents
    for (int k = 0; k < SYNTH_COUNT; k++) begin
      d = 16'($urandom());
      synth_exp[k] = d;
      wr(SYNTH_BASE + 16'(k), d);
      rd_chk(SYNTH_BASE + 16'(k), d);
    end
    i_host.spi_pulse();
    #1;
    check(spi_mode, 1'b1, "spi mode set");
    // Enter soft reset; pad forced home one cycle later
    wr(REINIT_ADDR, 16'h0000);
    check(soft_rst_b, 1'b0, "soft reset held");
    @(posedge i_mclk);
    #1;
    check(pad, 5'h08, "pad cleared");
    wr(PAD_CFG_ADDR, 16'h001b);
    rd_chk(PAD_CFG_ADDR, PAD_RESET);
    rd_chk(REINIT_ADDR, 16'h0000);
    check(synth, synth_exp, "synth kept");
    d = 16'($urandom());
    synth_exp[3] = d;
    wr(SYNTH_BASE + 16'h0003, d);
    rd_chk(SYNTH_BASE + 16'h0003, d);
    check(synth, synth_exp, "synth during soft reset");
    check(spi_mode, 1'b1, "spi during soft reset");
    // Release with reserved bits set
    wr(REINIT_ADDR, 16'hffff);
    check(soft_rst_b, 1'b1, "soft reset released");
    rd_chk(REINIT_ADDR, 16'h0001);
    check(spi_mode, 1'b1, "spi after soft reset");
    check(pad, 5'h08, "pad stays default");
    wr(PAD_CFG_ADDR, 16'h001b);
    check(pad, 5'h1b, "pad writable again");
    // Only the reset pin brings the port back to I2C
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    #1;
    check(spi_mode, 1'b0, "pin reset to i2c");
    check(pad, 5'h08, "pad after pin reset");
    check(synth, {SYNTH_COUNT{SYNTH_RESET}}, "synth pin reset");
    check(soft_rst_b, 1'b1, "run after pin reset");
    rd_chk(REINIT_ADDR, REINIT_RESET);
    finish_test();
  end
endmodule
